// ===== include/pmc_cfg.svh
// Offsets, field positions, reset values and the indicator count of the power control register
// How it works
// RULE1 - Register sits at byte offset 084h, 32 bits
// RULE2 - Bits 31:29 select state, reset 000
// RULE3 - Mode write dropped when sleep written 1
// RULE4 - Bit 28 enters sleep, reads 1 asleep
// RULE5 - Sleep write ignored when mode changes
// RULE6 - Host writes mode first, sleep later
// RULE7 - Host avoids sleep with full power selected
// RULE8 - Wake-up clears mode and sleep bits
// RULE9 - Bit 27 enables automatic wake-up; the code never wakes automatically from deep sleep
// RULE10 - Bit 26 undrives or idles indicator outputs
// RULE11 - Bit 25 needs two writes of 1
// RULE12 - Bit 22 needs two writes of 1
// RULE13 - Reads answered in reset-out or sleep
// RULE14 - Host distrusts reads while interface resets
// RULE15 - Partial byte reads are accepted
// RULE16 - Ready low asleep, high after stable D0
// RULE17 - Host wakes by access, polls test register
// RULE18 - Reserved bits read zero, ignore writes
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

`define PMC_ADDR_W          12
`define PMC_CTRL_OFFSET     12'h084
`define PMC_MODE_HI         31
`define PMC_MODE_LO         29
`define PMC_SLEEP_BIT       28
`define PMC_WAKE_EN_BIT     27
`define PMC_IND_OFF_BIT     26
`define PMC_PTP_OFF_BIT     25
`define PMC_TSU_OFF_BIT     22
`define PMC_READY_BIT       0
`define PMC_MODE_RESET      3'h0
`define PMC_BIT_RESET       1'h0
`define PMC_IND_COUNT       4
`define PMC_LANE_TOP        3

`endif

// ===== include/pmc_pkg.sv
// Types shared by the power control register block
package pmc_pkg;

  // Requested low-power state codes
  typedef enum logic [2:0] {
    PMC_FULL_POWER   = 3'h0,
    PMC_LIGHT_SLEEP  = 3'h1,
    PMC_MEDIUM_SLEEP = 3'h2,
    PMC_DEEP_SLEEP   = 3'h3
  } pmc_state_code_t;

  // Sequencer states
  typedef enum logic [1:0] {
    PMC_ST_AWAKE  = 2'h0,
    PMC_ST_ASLEEP = 2'h1,
    PMC_ST_WAKING = 2'h2
  } pmc_seq_t;

endpackage

// ===== logic/pmc_power_control.sv
// Power control register with sleep sequencer and indicator gating
`timescale 1ns/100ps
`include "pmc_cfg.svh"

module pmc_power_control
(
  input  wire logic                           i_ref_clk,       // 250 MHz clock
  input  wire logic                           i_sys_rst,       // Async reset, active high
  input  wire logic [`PMC_ADDR_W-1:0]         i_reg_addr,      // Byte address
  input  wire logic                           i_reg_wr,        // Write strobe, one cycle
  input  wire logic                           i_reg_rd,        // Read strobe, one cycle
  input  wire logic [3:0]                     i_reg_be,        // Byte enables
  input  wire logic [31:0]                    i_reg_wdata,     // Write data
  output logic      [31:0]                    o_reg_rdata,     // Read data, registered
  output logic                                o_reg_ack,       // Access done, one cycle
  input  wire logic                           i_pll_locked,    // Clock multiplier stable, async
  input  wire logic                           i_wake_event,    // Wake event level, async
  input  wire logic [`PMC_IND_COUNT-1:0]      i_ind_value,     // Requested indicator level
  input  wire logic [`PMC_IND_COUNT-1:0]      i_ind_oe_n,      // Requested enable, low drives
  input  wire logic [`PMC_IND_COUNT-1:0]      i_ind_push_pull, // 1 push-pull, 0 open type
  input  wire logic [`PMC_IND_COUNT-1:0]      i_ind_inactive,  // Inactive level per pin
  output logic      [`PMC_IND_COUNT-1:0]      o_ind_out,       // Indicator pin value
  output logic      [`PMC_IND_COUNT-1:0]      o_ind_oe_n,      // Indicator enable, low drives
  output logic      [2:0]                     o_power_state,   // State now in force
  output logic                                o_sleep_active,  // Low-power state entered
  output logic                                o_device_ready,  // Device ready indication
  output logic                                o_ptp_clk_off,   // Precision-time clocks gated
  output logic                                o_tsu_clk_off    // Timestamp clocks gated
);

  // Register fields
  logic [2:0]           power_state_select;    // Requested state
  logic                 sleep_request;         // Reads 1 while asleep
  logic                 auto_wake_enable;      // Wake events may wake
  logic                 indicator_outputs_off; // Indicators quieted
  logic [1:0]           guard_bit;             // Precision-time, timestamp clock off
  logic [1:0]           guard_armed;           // First write of 1 seen
  pmc_pkg::pmc_seq_t    seq;                   // Sequencer state
  pmc_pkg::pmc_seq_t    next_seq;              // Next sequencer state

  // Synchronisers for pins from outside the clock domain
  logic [1:0]           pll_sync;              // Stage 0 read only by stage 1
  logic [1:0]           wake_sync;             // Stage 0 read only by stage 1
  logic                 pll_stable;            // Settled lock level
  logic                 wake_seen;             // Settled wake level

  // Decoded access
  logic                 hit;                   // Address matches the register
  logic                 wr_hit;                // Write to the register while awake
  logic                 top_lane;              // Byte 3 written
  logic                 mode_changes;          // Write carries a new state code
  logic                 sleep_one;             // Write carries 1 into sleep bit
  logic                 manual_wake;           // Any host access while asleep
  logic                 auto_wake;             // Permitted wake event
  logic [31:0]          read_word;             // Assembled read value
  logic [31:0]          lane_mask;             // Byte lanes selected

  assign pll_stable = pll_sync[1];
  assign wake_seen  = wake_sync[1];

  // Two-flop synchronisers; only the second stage feeds logic
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      pll_sync  <= 2'h0;
      wake_sync <= 2'h0;
    end
    else
    begin
      pll_sync  <= {pll_sync[0], i_pll_locked};
      wake_sync <= {wake_sync[0], i_wake_event};
    end
  end

  // Address decode and write qualification
  always_comb
  begin
    hit          = (i_reg_addr == `PMC_CTRL_OFFSET); // RULE1
    // Writes while asleep only wake the device, their data is dropped
    wr_hit       = i_reg_wr && hit && (seq == pmc_pkg::PMC_ST_AWAKE);
    top_lane     = i_reg_be[`PMC_LANE_TOP];
    mode_changes = (i_reg_wdata[`PMC_MODE_HI:`PMC_MODE_LO] != power_state_select);
    sleep_one    = i_reg_wdata[`PMC_SLEEP_BIT];
  end

  // Wake sources
  always_comb
  begin
    manual_wake = (seq == pmc_pkg::PMC_ST_ASLEEP) && (i_reg_wr || i_reg_rd);
    // Deep sleep stops the oscillator, so only a host access can end it
    auto_wake   = (seq == pmc_pkg::PMC_ST_ASLEEP) && auto_wake_enable && wake_seen // RULE9
                  && (power_state_select != pmc_pkg::PMC_DEEP_SLEEP);
  end

  // Sequencer next state
  always_comb
  begin
    next_seq = seq;
    case (seq)
      pmc_pkg::PMC_ST_AWAKE:
      begin
        // Enter whatever state is held, full power code included
        if (wr_hit && top_lane && sleep_one && !mode_changes) // RULE4 RULE5
          next_seq = pmc_pkg::PMC_ST_ASLEEP;
      end
      pmc_pkg::PMC_ST_ASLEEP:
      begin
        if (manual_wake || auto_wake)
          next_seq = pmc_pkg::PMC_ST_WAKING;
      end
      pmc_pkg::PMC_ST_WAKING:
      begin
        // Back in full power once the multiplier has settled
        if (pll_stable) // RULE16
          next_seq = pmc_pkg::PMC_ST_AWAKE;
      end
      default:
      begin
        next_seq = pmc_pkg::PMC_ST_AWAKE;
      end
    endcase
  end

  // Sequencer state register
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      seq <= pmc_pkg::PMC_ST_AWAKE;
    else
      seq <= next_seq;
  end

  // State select field
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      power_state_select <= `PMC_MODE_RESET; // RULE2
    else if (seq == pmc_pkg::PMC_ST_WAKING && next_seq == pmc_pkg::PMC_ST_AWAKE)
      power_state_select <= `PMC_MODE_RESET; // RULE8
    else if (wr_hit && top_lane && !sleep_one) // RULE3
      power_state_select <= i_reg_wdata[`PMC_MODE_HI:`PMC_MODE_LO]; // RULE2
  end

  // Sleep bit: follows the sequencer, clears as full power returns
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      sleep_request <= `PMC_BIT_RESET;
    else if (next_seq == pmc_pkg::PMC_ST_ASLEEP)
      sleep_request <= 1'h1; // RULE4
    else if (next_seq == pmc_pkg::PMC_ST_AWAKE)
      sleep_request <= 1'h0; // RULE8
  end

  // Plain read-write control bits
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      auto_wake_enable      <= `PMC_BIT_RESET;
      indicator_outputs_off <= `PMC_BIT_RESET;
    end
    else if (wr_hit && top_lane)
    begin
      auto_wake_enable      <= i_reg_wdata[`PMC_WAKE_EN_BIT]; // RULE9
      indicator_outputs_off <= i_reg_wdata[`PMC_IND_OFF_BIT]; // RULE10
    end
  end

  // Guarded clock-off bits: a second consecutive write of 1 sets them
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : gen_guard
      localparam int POS = (g == 0) ? `PMC_PTP_OFF_BIT : `PMC_TSU_OFF_BIT;
      always_ff @(posedge i_ref_clk or posedge i_sys_rst)
      begin
        if (i_sys_rst)
        begin
          guard_bit[g]   <= `PMC_BIT_RESET;
          guard_armed[g] <= 1'h0;
        end
        else if (wr_hit && i_reg_be[POS/8])
        begin
          if (!i_reg_wdata[POS])
          begin
            // Zero clears the bit and restarts the count
            guard_bit[g]   <= 1'h0; // RULE11 RULE12
            guard_armed[g] <= 1'h0;
          end
          else if (guard_armed[g])
            guard_bit[g]   <= 1'h1; // RULE11 RULE12
          else
            guard_armed[g] <= 1'h1;
        end
      end
    end
  endgenerate

  // Read word; reserved positions stay zero
  always_comb
  begin
    read_word                                = 32'h0; // RULE18
    read_word[`PMC_MODE_HI:`PMC_MODE_LO]     = power_state_select;
    read_word[`PMC_SLEEP_BIT]                = sleep_request;
    read_word[`PMC_WAKE_EN_BIT]              = auto_wake_enable;
    read_word[`PMC_IND_OFF_BIT]              = indicator_outputs_off;
    read_word[`PMC_PTP_OFF_BIT]              = guard_bit[0];
    read_word[`PMC_TSU_OFF_BIT]              = guard_bit[1];
    read_word[`PMC_READY_BIT]                = o_device_ready;
    lane_mask = {{8{i_reg_be[3]}}, {8{i_reg_be[2]}}, {8{i_reg_be[1]}}, {8{i_reg_be[0]}}};
  end

  // Read and write answer; reads work in every sequencer state
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_reg_rdata <= 32'h0;
      o_reg_ack   <= 1'h0;
    end
    else
    begin
      o_reg_ack <= i_reg_wr || i_reg_rd; // RULE13
      if (i_reg_rd)
        // Unselected lanes and unmapped addresses read zero
        o_reg_rdata <= hit ? (read_word & lane_mask) : 32'h0; // RULE15
    end
  end

  // Status and clock-gate outputs
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_power_state  <= `PMC_MODE_RESET;
      o_sleep_active <= 1'h0;
      o_device_ready <= 1'h0;
      o_ptp_clk_off  <= 1'h0;
      o_tsu_clk_off  <= 1'h0;
    end
    else
    begin
      o_sleep_active <= (next_seq == pmc_pkg::PMC_ST_ASLEEP);
      o_power_state  <= (next_seq == pmc_pkg::PMC_ST_ASLEEP) ? power_state_select
                                                             : `PMC_MODE_RESET;
      // Drops on the cycle sleep starts, rises only in stable full power
      o_device_ready <= (next_seq == pmc_pkg::PMC_ST_AWAKE) && pll_stable; // RULE16
      o_ptp_clk_off  <= guard_bit[0]; // RULE11
      o_tsu_clk_off  <= guard_bit[1]; // RULE12
    end
  end

  // Indicator pins: open types released, push-pull held inactive
  generate
    for (g = 0; g < `PMC_IND_COUNT; g = g + 1)
    begin : gen_ind
      always_ff @(posedge i_ref_clk or posedge i_sys_rst)
      begin
        if (i_sys_rst)
        begin
          o_ind_out[g]  <= 1'h0;
          o_ind_oe_n[g] <= 1'h1;
        end
        else if (indicator_outputs_off && i_ind_push_pull[g])
        begin
          o_ind_out[g]  <= i_ind_inactive[g]; // RULE10
          o_ind_oe_n[g] <= 1'h0;
        end
        else if (indicator_outputs_off)
        begin
          o_ind_out[g]  <= i_ind_inactive[g];
          o_ind_oe_n[g] <= 1'h1; // RULE10
        end
        else
        begin
          o_ind_out[g]  <= i_ind_value[g];
          o_ind_oe_n[g] <= i_ind_oe_n[g];
        end
      end
    end
  endgenerate

endmodule

// ===== tb/pmc_power_control_props.sv
// Concurrent checks on the power control register ports
`timescale 1ns/100ps
`include "pmc_cfg.svh"
module pmc_power_control_props
(
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_sys_rst,
  input  wire logic [`PMC_ADDR_W-1:0]    i_reg_addr,
  input  wire logic                      i_reg_wr,
  input  wire logic                      i_reg_rd,
  input  wire logic [3:0]                i_reg_be,
  input  wire logic [31:0]               i_reg_wdata,
  input  wire logic [31:0]               o_reg_rdata,
  input  wire logic                      o_reg_ack,
  input  wire logic                      i_pll_locked,
  input  wire logic [`PMC_IND_COUNT-1:0] i_ind_value,
  input  wire logic [`PMC_IND_COUNT-1:0] i_ind_push_pull,
  input  wire logic [`PMC_IND_COUNT-1:0] o_ind_out,
  input  wire logic [`PMC_IND_COUNT-1:0] o_ind_oe_n,
  input  wire logic [2:0]                o_power_state,
  input  wire logic                      o_sleep_active,
  input  wire logic                      o_device_ready,
  input  wire logic                      o_ptp_clk_off,
  input  wire logic                      o_tsu_clk_off
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  logic wr_hit; // Write aimed at this register
  assign wr_hit = i_reg_wr && (i_reg_addr == `PMC_CTRL_OFFSET);
  // Any bus request
  sequence s_strobe;
    i_reg_wr || i_reg_rd;
  endsequence
  // Back at full power with a stable clock
  sequence s_ready_back;
    !o_sleep_active && (o_power_state == 3'h0) && $past(i_pll_locked);
  endsequence
  ack_after_strobe_a: assert property (s_strobe |=> o_reg_ack)
    else $error("no ack after a request");
  ack_cause_a: assert property (o_reg_ack |-> $past(i_reg_wr || i_reg_rd))
    else $error("ack without a request");
  reserved_zero_a: assert property (o_reg_ack |-> {o_reg_rdata[24:23], o_reg_rdata[21:1]} == 23'h0)
    else $error("reserved bits read nonzero");
  asleep_not_ready_a: assert property (o_sleep_active |-> !o_device_ready)
    else $error("ready while asleep");
  ready_rise_a: assert property ($rose(o_device_ready) |-> s_ready_back)
    else $error("ready rose outside full power");
  awake_state_a: assert property (!o_sleep_active |-> o_power_state == 3'h0)
    else $error("state code left after wake");
  sleep_cause_a: assert property ($rose(o_sleep_active) |->
    $past(wr_hit && i_reg_be[3] && i_reg_wdata[28]) && o_power_state == $past(i_reg_wdata[31:29]))
    else $error("sleep entered without matching request");
  ptp_set_a: assert property ($rose(o_ptp_clk_off) |-> $past(wr_hit && i_reg_wdata[25], 2))
    else $error("precision clock gated without write");
  tsu_set_a: assert property ($rose(o_tsu_clk_off) |-> $past(wr_hit && i_reg_wdata[22], 2))
    else $error("timestamp clock gated without write");
  ind_follow_a: assert property (!o_ind_oe_n[2] && !$past(i_ind_push_pull[2]) |->
    o_ind_out[2] == $past(i_ind_value[2]))
    else $error("driven open pin not following request");
endmodule
bind pmc_power_control pmc_power_control_props u_props (.*);

// ===== tb/pmc_host_model.sv
// Host processor model issuing register reads and writes
`timescale 1ns/100ps
module pmc_host_model
(
  input  wire logic        i_clk,
  input  wire logic        i_ack,
  input  wire logic [31:0] i_rdata,
  output logic      [11:0] o_addr,
  output logic             o_wr,
  output logic             o_rd,
  output logic      [3:0]  o_be,
  output logic      [31:0] o_wdata
);
  int n_late = 0; // Accesses that never saw an ack
  // Idle bus from time zero; no access is issued while reset holds
  initial
  begin
    o_addr = 12'h000;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_be = 4'h0;
    o_wdata = 32'h0;
  end
  // One access: strobe for a single edge, qualifiers held until ack
  // Any access also serves as the manual wake request
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [3:0] be,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(negedge i_clk);
    o_addr = a;
    o_be = be;
    o_wdata = d;
    o_wr = wr;
    o_rd = !wr;
    @(negedge i_clk);
    o_wr = 1'b0; // Pulse only, a held strobe would be taken twice
    o_rd = 1'b0;
    // Ack rose at the edge just passed and stands until the next one
    while (i_ack !== 1'b1 && n < 8)
    begin
      @(negedge i_clk);
      n++;
    end
    if (i_ack !== 1'b1)
      n_late++;
    q = i_rdata;
    // Qualifiers stay through the edge that samples ack, then release
    @(negedge i_clk);
    o_addr = ~o_addr; // Released lines show no stale value
    o_wdata = ~o_wdata;
  endtask
endmodule

// ===== tb/testbench.sv
// Self-checking testbench for the power control register
`timescale 1ns/100ps
`include "pmc_cfg.svh"
module testbench;
  logic        ref_clk = 1'b0;    // Bus clock
  logic        sys_rst = 1'b1;    // Held at start
  logic        pll_ok  = 1'b1;    // Clock multiplier stable
  logic        wake_ev = 1'b0;    // Wake event level
  logic [11:0] addr;              // Host bus lines
  logic        wr, rd, ack, sleep, ready, ptp_off, tsu_off;
  logic [3:0]  be, ind_out, ind_oe_n;
  logic [31:0] wdata, rdata;
  logic [2:0]  state;             // State code in force
  int          fails = 0;
  int          n_tests = 0;
  always #2 ref_clk = ~ref_clk;   // 250 MHz
  pmc_power_control u_dut (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_be(be), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_reg_ack(ack), .i_pll_locked(pll_ok), .i_wake_event(wake_ev), .i_ind_value(4'hF),
    .i_ind_oe_n(4'h0), .i_ind_push_pull(4'h3), .i_ind_inactive(4'h0), .o_ind_out(ind_out),
    .o_ind_oe_n(ind_oe_n), .o_power_state(state), .o_sleep_active(sleep),
    .o_device_ready(ready), .o_ptp_clk_off(ptp_off), .o_tsu_clk_off(tsu_off));
  pmc_host_model u_host (.i_clk(ref_clk), .i_ack(ack), .i_rdata(rdata), .o_addr(addr),
    .o_wr(wr), .o_rd(rd), .o_be(be), .o_wdata(wdata));
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // Register write, answer data unused
  task automatic wreg(input logic [3:0] b, input logic [31:0] d);
    logic [31:0] q;
    u_host.xfer(1'b1, `PMC_CTRL_OFFSET, b, d, q);
  endtask
  // Register read with expected word
  task automatic rreg(input logic [11:0] a, input logic [3:0] b, input logic [31:0] exp);
    logic [31:0] q;
    u_host.xfer(1'b0, a, b, 32'h0, q);
    chk(q, exp);
  endtask
  // Sleep flag, state code and ready packed for one compare
  function automatic logic [31:0] stat();
    return {27'h0, sleep, state, ready};
  endfunction
  task automatic wrap_up;
    fails = fails + u_host.n_late;
    $display("checks=%0d errors=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Hang guard, far beyond the roughly 130 cycles of the run
  initial
  begin
    #20000;
    fails++;
    wrap_up();
  end
  initial
  begin
    repeat (12) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    rreg(`PMC_CTRL_OFFSET, 4'hF, 32'h0000_0001);
    rreg(12'h088, 4'hF, 32'h0);
    wreg(4'hF, 32'h0FFF_FFFF);
    rreg(`PMC_CTRL_OFFSET, 4'hF, 32'h0C00_0001);
    @(negedge ref_clk);
    chk({24'h0, ind_oe_n, ind_out}, 32'h0000_00C0);
    wreg(4'hF, 32'h0);
    chk({24'h0, ind_oe_n, ind_out}, 32'h0000_000F);
    wreg(4'hF, 32'h0240_0000);
    chk({30'h0, ptp_off, tsu_off}, 32'h0);
    wreg(4'hF, 32'h0240_0000);
    rreg(`PMC_CTRL_OFFSET, 4'h8, 32'h0200_0000);
    rreg(`PMC_CTRL_OFFSET, 4'h4, 32'h0040_0000);
    chk({30'h0, ptp_off, tsu_off}, 32'h3);
    wreg(4'hF, 32'h4000_0000);
    wreg(4'hF, 32'h3000_0000);
    rreg(`PMC_CTRL_OFFSET, 4'hF, 32'h4000_0001);
    wreg(4'hF, 32'h5000_0000);
    @(negedge ref_clk);
    chk(stat(), 32'h14);
    rreg(`PMC_CTRL_OFFSET, 4'hF, 32'h5000_0000);
    repeat (8) @(negedge ref_clk);
    rreg(`PMC_CTRL_OFFSET, 4'hF, 32'h0000_0001);
    wreg(4'hF, 32'h2800_0000);
    wreg(4'hF, 32'h3800_0000);
    wake_ev = 1'b1;
    repeat (10) @(negedge ref_clk);
    chk(stat(), 32'h1);
    wake_ev = 1'b0;
    rreg(`PMC_CTRL_OFFSET, 4'hF, 32'h0800_0001);
    wreg(4'hF, 32'h6800_0000);
    wreg(4'hF, 32'h7800_0000);
    wake_ev = 1'b1;
    repeat (10) @(negedge ref_clk);
    chk(stat(), 32'h16);
    wake_ev = 1'b0;
    pll_ok = 1'b0;
    rreg(`PMC_CTRL_OFFSET, 4'h8, 32'h7800_0000);
    repeat (10) @(negedge ref_clk);
    chk(stat(), 32'h0);
    pll_ok = 1'b1;
    repeat (10) @(negedge ref_clk);
    chk(stat(), 32'h1);
    wrap_up();
  end
endmodule
